// ===== rtl/io_read_watchdog_timer.sv
// i/o-read watchdog: enable/refresh and disable by port reads, expiry action by jumper
// assumes host i/o read cycles much longer than the 50 ns board clock
// Behaviour
// RULE1 - a read of port 0x443 enables the watchdog and starts its countdown.
// RULE2 - further reads of 0x443 while enabled reload the full timeout period.
// RULE3 - a read of port 0x043 stops and disables the countdown.
// RULE4 - on expiry the watchdog pulses a cold reset or an nmi per the action jumper.
// RULE5 - the period comes from the period jumper, never from software.
// RULE6 - the host should refresh with at least thirty percent margin.
// RULE7 - the host must read the disable port before its program ends.
// RULE8 - after system reset the watchdog is disabled until the first enable read.
`timescale 1ns/1ps
`default_nettype none
module io_read_watchdog_timer #(
  parameter longint unsigned PERIOD0_CYCLES =
    io_watchdog_pkg::PERIOD0_MS * io_watchdog_pkg::CLK_HZ / 64'd1000,
  parameter longint unsigned PERIOD1_CYCLES =
    io_watchdog_pkg::PERIOD1_MS * io_watchdog_pkg::CLK_HZ / 64'd1000,
  parameter longint unsigned PERIOD2_CYCLES =
    io_watchdog_pkg::PERIOD2_MS * io_watchdog_pkg::CLK_HZ / 64'd1000,
  parameter longint unsigned PERIOD3_CYCLES =
    io_watchdog_pkg::PERIOD3_MS * io_watchdog_pkg::CLK_HZ / 64'd1000
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [15:0] ioAddr,
  input  wire logic        ioRead_n,
  input  wire logic        timeout_action_jumper,
  input  wire logic [1:0]  timeout_period_jumper,
  output logic [7:0]       ioReadData,
  output logic             coldReset,
  output logic             nmiOut,
  output logic             watchdogActive
);
  io_watchdog_bus_if hits ();

  io_port_decoder u_decoder (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .ioAddr   (ioAddr),
    .ioRead_n (ioRead_n),
    .hits     (hits.decoder)
  );

  // jumpers are static pins but still pass two flops
  logic       actMeta_reg, actSync_reg;
  logic [1:0] perMeta_reg, perSync_reg;
  always_ff @(posedge clk) begin
    actMeta_reg <= timeout_action_jumper;
    actSync_reg <= actMeta_reg;
    perMeta_reg <= timeout_period_jumper;
    perSync_reg <= perMeta_reg;
  end

  // RULE5 period from jumper only
  logic [31:0] reloadValue;
  always_comb begin
    case (perSync_reg)
      2'h0:    reloadValue = 32'(PERIOD0_CYCLES);
      2'h1:    reloadValue = 32'(PERIOD1_CYCLES);
      2'h2:    reloadValue = 32'(PERIOD2_CYCLES);
      default: reloadValue = 32'(PERIOD3_CYCLES);
    endcase
  end

  io_watchdog_pkg::wd_state_type state_reg, state_next;
  logic [31:0] count_reg, count_next;
  logic        reset_reg, reset_next, nmi_reg, nmi_next;
  logic [7:0]  data_reg, data_next;

  // countdown state machine; disable beats enable when both hit (cannot both match)
  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    reset_next = 1'b0;
    nmi_next   = 1'b0;
    data_next  = (hits.enableHit || hits.disableHit) ? io_watchdog_pkg::PORT_READ_DATA : data_reg;
    case (state_reg)
      io_watchdog_pkg::WD_IDLE: begin
        // RULE1 enable starts countdown
        if (hits.enableHit) begin
          state_next = io_watchdog_pkg::WD_COUNT;
          count_next = reloadValue;
        end
      end
      io_watchdog_pkg::WD_COUNT: begin
        if (hits.disableHit) begin
          // RULE3 disable stops countdown
          state_next = io_watchdog_pkg::WD_IDLE;
          count_next = io_watchdog_pkg::COUNT_RESET;
        end else if (hits.enableHit) begin
          // RULE2 refresh reloads period
          count_next = reloadValue;
        end else if (count_reg <= 32'h00000001) begin
          // RULE4 expiry fires the jumper action
          state_next = io_watchdog_pkg::WD_FIRE;
          count_next = 32'(io_watchdog_pkg::EXPIRE_PULSE_CYCLES);
          // raise here, else the pulse comes out one cycle short of its count
          reset_next = (actSync_reg == io_watchdog_pkg::ACTION_RESET);
          nmi_next   = (actSync_reg == io_watchdog_pkg::ACTION_NMI);
        end else begin
          count_next = count_reg - 32'h00000001;
        end
      end
      io_watchdog_pkg::WD_FIRE: begin
        // RULE4 hold action pulse, then idle
        reset_next = (actSync_reg == io_watchdog_pkg::ACTION_RESET);
        nmi_next   = (actSync_reg == io_watchdog_pkg::ACTION_NMI);
        if (count_reg <= 32'h00000001) begin
          state_next = io_watchdog_pkg::WD_IDLE;
          count_next = io_watchdog_pkg::COUNT_RESET;
          reset_next = 1'b0;
          nmi_next   = 1'b0;
        end else begin
          count_next = count_reg - 32'h00000001;
        end
      end
      default: begin
        state_next = io_watchdog_pkg::WD_IDLE;
        count_next = io_watchdog_pkg::COUNT_RESET;
      end
    endcase
    // RULE8 reset leaves it disabled
    if (sys_rst) begin
      state_next = io_watchdog_pkg::WD_IDLE;
      count_next = io_watchdog_pkg::COUNT_RESET;
      reset_next = 1'b0;
      nmi_next   = 1'b0;
      data_next  = 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    state_reg <= state_next;
    count_reg <= count_next;
    reset_reg <= reset_next;
    nmi_reg   <= nmi_next;
    data_reg  <= data_next;
  end

  assign coldReset      = reset_reg;
  assign nmiOut         = nmi_reg;
  assign ioReadData     = data_reg;
  assign watchdogActive = (state_reg == io_watchdog_pkg::WD_COUNT);

  // assertions
  property p_enable_starts;
    @(posedge clk) disable iff (sys_rst)
      (state_reg == io_watchdog_pkg::WD_IDLE && hits.enableHit) |=> watchdogActive;
  endproperty
  a_enable_starts: assert property (p_enable_starts) // RULE1
    else $error("enable read did not start countdown");

  property p_refresh_reloads;
    @(posedge clk) disable iff (sys_rst)
      (watchdogActive && hits.enableHit && !hits.disableHit) |=> (count_reg == $past(reloadValue));
  endproperty
  a_refresh_reloads: assert property (p_refresh_reloads) // RULE2
    else $error("refresh did not reload period");

  property p_disable_stops;
    @(posedge clk) disable iff (sys_rst)
      (watchdogActive && hits.disableHit) |=> !watchdogActive && !coldReset && !nmiOut;
  endproperty
  a_disable_stops: assert property (p_disable_stops) // RULE3
    else $error("disable read did not stop countdown");

  sequence s_expire;
    watchdogActive && !hits.enableHit && !hits.disableHit && count_reg == 32'h00000001;
  endsequence
  property p_expire_action;
    @(posedge clk) disable iff (sys_rst)
      s_expire ##1 1'b1 |=> (coldReset == (actSync_reg == io_watchdog_pkg::ACTION_RESET))
        && (nmiOut == (actSync_reg == io_watchdog_pkg::ACTION_NMI));
  endproperty
  a_expire_action: assert property (p_expire_action) // RULE4
    else $error("expiry action does not follow jumper");

  property p_no_action_while_counting;
    @(posedge clk) disable iff (sys_rst)
      watchdogActive |-> !coldReset && !nmiOut;
  endproperty
  a_no_action_while_counting: assert property (p_no_action_while_counting) // RULE4
    else $error("action raised while counting");

  property p_count_decrements;
    @(posedge clk) disable iff (sys_rst)
      (watchdogActive && !hits.enableHit && !hits.disableHit && count_reg > 32'h00000001)
        |=> count_reg == $past(count_reg) - 32'h00000001;
  endproperty
  a_count_decrements: assert property (p_count_decrements) // RULE5
    else $error("countdown did not step");

  property p_reset_idle;
    @(posedge clk) sys_rst |=> !watchdogActive && !coldReset && !nmiOut;
  endproperty
  a_reset_idle: assert property (p_reset_idle) // RULE8
    else $error("watchdog not idle after reset");

  property p_idle_stays;
    @(posedge clk) disable iff (sys_rst)
      (state_reg == io_watchdog_pkg::WD_IDLE && !hits.enableHit) |=> !watchdogActive;
  endproperty
  a_idle_stays: assert property (p_idle_stays) // RULE8
    else $error("countdown started without enable read");

  // helper: cycles the expiry action has stood so far
  logic [31:0] pulseLen_reg, pulseLen_next;
  always_comb begin
    pulseLen_next = (coldReset || nmiOut) ? pulseLen_reg + 32'h00000001 : 32'h00000000;
    if (sys_rst) begin
      pulseLen_next = 32'h00000000;
    end
  end

  always_ff @(posedge clk) begin
    pulseLen_reg <= pulseLen_next;
  end

  // RULE4 pulse holds its full length
  property p_pulse_length;
    @(posedge clk) disable iff (sys_rst)
      $fell(coldReset || nmiOut) |-> pulseLen_reg == 32'(io_watchdog_pkg::EXPIRE_PULSE_CYCLES);
  endproperty
  a_pulse_length: assert property (p_pulse_length) // RULE4
    else $error("expiry pulse length wrong");

  // RULE4 only one action per expiry
  property p_single_action;
    @(posedge clk) disable iff (sys_rst)
      !(coldReset && nmiOut);
  endproperty
  a_single_action: assert property (p_single_action) // RULE4
    else $error("reset and nmi raised together");
endmodule : io_read_watchdog_timer
`default_nettype wire

// ===== rtl/io_watchdog_pkg.sv
// package for the i/o-read watchdog: port addresses, jumper codes, timing
// assumes a 20 MHz board clock and an isa-style i/o read strobe
package io_watchdog_pkg;

  localparam int unsigned ADDR_WIDTH         = 16;
  // i/o port that enables and refreshes the countdown
  localparam logic [15:0] ENABLE_PORT_ADDR   = 16'h0443;
  // i/o port that disables the countdown
  localparam logic [15:0] DISABLE_PORT_ADDR  = 16'h0043;
  localparam logic [7:0]  PORT_READ_DATA     = 8'hff;

  // board clock
  localparam longint unsigned CLK_HZ         = 64'd20000000;
  // selectable timeout periods, milliseconds
  localparam longint unsigned PERIOD0_MS     = 64'd1000;
  localparam longint unsigned PERIOD1_MS     = 64'd2000;
  localparam longint unsigned PERIOD2_MS     = 64'd5000;
  localparam longint unsigned PERIOD3_MS     = 64'd10000;
  // expiry pulse length in nanoseconds and cycles (least time, rounded up)
  localparam longint unsigned EXPIRE_PULSE_NS = 64'd1000;
  localparam int unsigned EXPIRE_PULSE_CYCLES =
    int'((EXPIRE_PULSE_NS * CLK_HZ + 64'd999999999) / 64'd1000000000);
  localparam int unsigned COUNT_WIDTH        = 32;
  localparam logic [31:0] COUNT_RESET        = 32'h00000000;

  // action jumper encoding
  localparam logic ACTION_RESET = 1'b0;
  localparam logic ACTION_NMI   = 1'b1;

  typedef enum logic [1:0] {
    WD_IDLE,
    WD_COUNT,
    WD_FIRE
  } wd_state_type;

endpackage : io_watchdog_pkg

// ===== rtl/io_watchdog_bus_if.sv
// interface between the watchdog top and its port decoder
// assumes all signals on clk
`timescale 1ns/1ps
`default_nettype none
interface io_watchdog_bus_if;
  logic enableHit;
  logic disableHit;
  modport decoder (output enableHit, output disableHit);
  modport core    (input enableHit, input disableHit);
endinterface : io_watchdog_bus_if
`default_nettype wire

// ===== rtl/io_port_decoder.sv
// i/o read decoder: synchronises the read strobe and flags port hits
// assumes address is stable while the read strobe is low
`timescale 1ns/1ps
`default_nettype none
module io_port_decoder (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic [15:0]           ioAddr,
  input  wire logic                  ioRead_n,
  io_watchdog_bus_if.decoder         hits
);
  logic [15:0] addrMeta_reg, addrSync_reg, addrMeta_next, addrSync_next;
  logic [2:0]  rdSh_reg, rdSh_next;

  // two-stage synchroniser plus one edge stage for the strobe
  always_comb begin
    addrMeta_next = ioAddr;
    addrSync_next = addrMeta_reg;
    rdSh_next     = {rdSh_reg[1:0], ~ioRead_n};
    if (sys_rst) begin
      rdSh_next = 3'h0;
    end
  end

  always_ff @(posedge clk) begin
    addrMeta_reg <= addrMeta_next;
    addrSync_reg <= addrSync_next;
    rdSh_reg     <= rdSh_next;
  end

  // one pulse per read cycle, at the strobe's leading edge
  logic readStart;
  assign readStart       = rdSh_reg[1] & ~rdSh_reg[2];
  assign hits.enableHit  = readStart && (addrSync_reg == io_watchdog_pkg::ENABLE_PORT_ADDR);
  assign hits.disableHit = readStart && (addrSync_reg == io_watchdog_pkg::DISABLE_PORT_ADDR);
endmodule : io_port_decoder
`default_nettype wire

// ===== tb/io_host_model.sv
// host model: runs i/o read cycles on the watchdog's port pins
// assumes the board clock; the bench calls ioRead from one thread only
`timescale 1ns/1ps
`default_nettype none
module io_host_model (
  input  wire logic        clk,
  output logic      [15:0] ioAddr,
  output logic             ioRead_n,
  input  wire logic [7:0]  ioReadData,
  output logic      [7:0]  lastData
);
  initial begin
    ioAddr = 16'h0000;
    ioRead_n = 1'b1;
    lastData = 8'h00;
  end

  // address leads the strobe by 3 cycles, strobe low 6, high 3 after
  task automatic ioRead(input logic [15:0] addr);
    @(posedge clk);
    #2 ioAddr <= addr;
    repeat (3) @(posedge clk);
    #2 ioRead_n <= 1'b0;
    repeat (6) @(posedge clk);
    lastData = ioReadData;
    #2 ioRead_n <= 1'b1;
    // a released bus shows the inverse, never a stale valid address
    ioAddr <= ~addr;
    repeat (3) @(posedge clk);
  endtask : ioRead
endmodule : io_host_model
`default_nettype wire

// ===== tb/io_read_watchdog_timer_tb.sv
// bench for the i/o-read watchdog: enable, refresh, disable and expiry
// assumes short period parameters so every expiry fits a short run
`timescale 1ns/1ps
`default_nettype none
module io_read_watchdog_timer_tb;
  localparam int PULSE = io_watchdog_pkg::EXPIRE_PULSE_CYCLES;
  localparam int PER[4] = '{50, 100, 150, 200};
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        actionJumper = 1'b0;
  logic [1:0]  periodJumper = 2'h0;
  logic [15:0] ioAddr;
  logic        ioRead_n;
  logic [7:0]  ioReadData;
  logic [7:0]  hostData;
  logic        coldReset;
  logic        nmiOut;
  logic        watchdogActive;
  int          errors = 0;
  int          samples_checked = 0;

  always #25 clk = ~clk;

  io_host_model i_host (
    .clk        (clk),
    .ioAddr     (ioAddr),
    .ioRead_n   (ioRead_n),
    .ioReadData (ioReadData),
    .lastData   (hostData)
  );

  // short periods so every expiry fits the run
  io_read_watchdog_timer #(
    .PERIOD0_CYCLES (50),
    .PERIOD1_CYCLES (100),
    .PERIOD2_CYCLES (150),
    .PERIOD3_CYCLES (200)
  ) i_dut (
    .clk                   (clk),
    .sys_rst               (sys_rst),
    .ioAddr                (ioAddr),
    .ioRead_n              (ioRead_n),
    .timeout_action_jumper (actionJumper),
    .timeout_period_jumper (periodJumper),
    .ioReadData            (ioReadData),
    .coldReset             (coldReset),
    .nmiOut                (nmiOut),
    .watchdogActive        (watchdogActive)
  );

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wrap_up;
    $display("comparisons %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  // bounded wait for either expiry output; a hang ends the run
  task automatic waitFire(output int n);
    n = 0;
    while (coldReset !== 1'b1 && nmiOut !== 1'b1) begin
      @(posedge clk);
      #1 n++;
      if (n > 1000) begin
        errors++;
        wrap_up();
      end
    end
  endtask : waitFire

  // idle after reset, stray address ignored, second reset mid-count
  task automatic resetState;
    check({watchdogActive, coldReset, nmiOut}, 0);
    i_host.ioRead(16'h0444);
    repeat (60) @(posedge clk);
    check({watchdogActive, coldReset, nmiOut}, 0);
    i_host.ioRead(16'h0443);
    check(watchdogActive, 1);
    #2 sys_rst = 1'b1;
    repeat (3) @(posedge clk);
    #2 sys_rst = 1'b0;
    repeat (80) @(posedge clk);
    check({watchdogActive, coldReset, nmiOut}, 0);
  endtask : resetState

  // every period and action: time to expiry, pulse kind and length
  task automatic expireAll;
    int n;
    int w;
    for (int a = 0; a < 8; a++) begin
      @(posedge clk);
      #2 periodJumper = a[1:0];
      actionJumper = a[2];
      repeat (4) @(posedge clk);
      i_host.ioRead(16'h0443);
      check(hostData, 8'hff);
      check(watchdogActive, 1);
      waitFire(n);
      check(n >= PER[a%4] - 12 && n <= PER[a%4], 1);
      check({coldReset, nmiOut}, a[2] ? 2'h1 : 2'h2);
      check(watchdogActive, 0);
      w = 0;
      while ((coldReset | nmiOut) === 1'b1 && w < 100) begin
        @(posedge clk);
        #1 w++;
      end
      // a pulse that never ends is a hang
      if (w >= 100) begin
        errors++;
        wrap_up();
      end
      check(w, PULSE);
    end
  endtask : expireAll

  // refresh well inside the period, then disable before leaving
  task automatic refreshThenDisable;
    @(posedge clk);
    #2 periodJumper = 2'h0;
    i_host.ioRead(16'h0443);
    for (int i = 0; i < 4; i++) begin
      repeat (20) @(posedge clk);
      i_host.ioRead(16'h0443);
      check({watchdogActive, coldReset, nmiOut}, 3'h4);
    end
    i_host.ioRead(16'h0043);
    check(watchdogActive, 0);
    repeat (120) @(posedge clk);
    check({watchdogActive, coldReset, nmiOut}, 0);
  endtask : refreshThenDisable

  initial begin
    repeat (16) @(posedge clk);
    #2 sys_rst = 1'b0;
    @(posedge clk);
    resetState();
    expireAll();
    refreshThenDisable();
    wrap_up();
  end
endmodule : io_read_watchdog_timer_tb
`default_nettype wire
